// File: edcc_top.sv
// Register file, APB slave and update logic of the excitation DAC control.
`timescale 1ns/1ns
module edcc_top
    import edcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog controls
    output logic             ampGainSelect,
    output logic             attenuatorEnable,
    output logic             highSpeedMode,
    // Converter code
    output logic      [12:0] dacCode,
    output logic             dacUpdate
);
    import edcc_pkg::*;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        gainSel;
        logic [2:0]  cfgSpare;
        logic [7:0]  rate;
        logic        atten;
        logic [11:0] code;
        logic [31:0] lockKey;
        logic [11:0] gainTrim;
        logic [11:0] offAttLp;
        logic [11:0] offDirLp;
        logic [11:0] offAttHs;
        logic [11:0] offDirHs;
        logic        highSpeed;
        logic [12:0] dacOut;
        logic        dacUpdate;
    } edcc_top_state_t;

    edcc_top_state_t s;
    edcc_top_state_t next_s;

    logic        tick;
    logic [11:0] selOffset;
    logic [12:0] trimmed;
    logic        setupPhase;
    logic        accessPhase;
    logic        unlocked;
    logic        readHit;
    logic [31:0] readData;
    logic [31:0] oldWord;
    logic [31:0] newWord;

    // ==========================================================
    // Helper functions

    // Merges the written bytes selected by the strobes into a word.
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldValue,
        input logic [31:0] wdata,
        input logic [3:0]  strb
    );
        logic [31:0] result;
        result = oldValue;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // Widens a 12-bit field to a bus word.
    function automatic logic [31:0] word12(input logic [11:0] v);
        return {20'h00000, v};
    endfunction

    // ==========================================================
    // Update-rate divider and trim datapath
    edcc_rate_divider uDivider (
        .clk    (clk),
        .resetn (resetn),
        .rate   (s.rate),
        .tick   (tick)
    );

    always_comb begin
        unique case ({s.highSpeed, s.atten})
            2'b00: selOffset = s.offDirLp;
            2'b01: selOffset = s.offAttLp;
            2'b10: selOffset = s.offDirHs;
            2'b11: selOffset = s.offAttHs;
        endcase
    end

    edcc_trim_path uTrim (
        .code       (s.code),
        .gainTrim   (s.gainTrim),
        .offsetTrim (selOffset),
        .trimmed    (trimmed)
    );

    // ==========================================================
    // Address decode and read data
    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable & s.pready;
    assign unlocked    = (s.lockKey == EDCC_UNLOCK_KEY);

    always_comb begin
        readHit  = 1'b1;
        readData = 32'h00000000;
        unique case (paddr)
            EDCC_CONFIG_OFF: begin
                readData[EDCC_GAIN_SEL_BIT]           = s.gainSel;
                readData[EDCC_SPARE_LSB +: 3]         = s.cfgSpare;
                readData[EDCC_RATE_LSB +: 8]          = s.rate;
                readData[EDCC_ATTEN_BIT]              = s.atten;
            end
            EDCC_CODE_OFF:   readData = word12(s.code);
            EDCC_LOCK_OFF:   readData = s.lockKey;
            EDCC_GAIN_OFF:   readData = word12(s.gainTrim);
            EDCC_OFF_ATT_LP: readData = word12(s.offAttLp);
            EDCC_OFF_DIR_LP: readData = word12(s.offDirLp);
            EDCC_OFF_ATT_HS: readData = word12(s.offAttHs);
            EDCC_OFF_DIR_HS: readData = word12(s.offDirHs);
            EDCC_MODE_OFF:   readData[0] = s.highSpeed;
            EDCC_STATUS_OFF: begin
                readData[12:0]              = s.dacOut;
                readData[EDCC_UNLOCKED_BIT] = unlocked;
            end
            default:         readHit = 1'b0;
        endcase
    end

    // Current register word at the address, merged with the write.
    assign oldWord = readData;
    assign newWord = mergeBytes(oldWord, pwdata, pstrb);

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s           = s;
        next_s.dacUpdate = 1'b0;

        // Zero-wait slave: ready and answer are prepared in setup.
        if (setupPhase) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = ~readHit;
            next_s.prdata  = (pwrite || !readHit) ? 32'h00000000 : readData;
        end else begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
        end

        if (accessPhase && pwrite && !s.pslverr) begin
            unique case (paddr)
                EDCC_CONFIG_OFF: begin
                    next_s.gainSel  = newWord[EDCC_GAIN_SEL_BIT];
                    next_s.cfgSpare = newWord[EDCC_SPARE_LSB +: 3];
                    next_s.rate     = newWord[EDCC_RATE_LSB +: 8];
                    next_s.atten    = newWord[EDCC_ATTEN_BIT];
                end
                EDCC_CODE_OFF: next_s.code = newWord[11:0];
                EDCC_LOCK_OFF: next_s.lockKey = newWord;
                EDCC_MODE_OFF: next_s.highSpeed = newWord[0];
                default: begin
                    if (unlocked) begin
                        if (paddr == EDCC_GAIN_OFF) begin
                            next_s.gainTrim = newWord[11:0];
                        end
                        if (paddr == EDCC_OFF_ATT_LP) begin
                            next_s.offAttLp = newWord[11:0];
                        end
                        if (paddr == EDCC_OFF_DIR_LP) begin
                            next_s.offDirLp = newWord[11:0];
                        end
                        if (paddr == EDCC_OFF_ATT_HS) begin
                            next_s.offAttHs = newWord[11:0];
                        end
                        if (paddr == EDCC_OFF_DIR_HS) begin
                            next_s.offDirHs = newWord[11:0];
                        end
                    end
                end
            endcase
        end

        if (tick) begin
            next_s.dacOut    = trimmed;
            next_s.dacUpdate = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s          <= '0;
            s.gainSel  <= EDCC_CONFIG_RST[EDCC_GAIN_SEL_BIT];
            s.cfgSpare <= EDCC_CONFIG_RST[EDCC_SPARE_LSB +: 3];
            s.rate     <= EDCC_CONFIG_RST[EDCC_RATE_LSB +: 8];
            s.atten    <= EDCC_CONFIG_RST[EDCC_ATTEN_BIT];
            s.code     <= EDCC_CODE_RST;
            s.lockKey  <= EDCC_LOCK_RST;
            s.gainTrim <= EDCC_GAIN_RST;
            s.offAttLp <= EDCC_OFFSET_RST;
            s.offDirLp <= EDCC_OFFSET_RST;
            s.offAttHs <= EDCC_OFFSET_RST;
            s.offDirHs <= EDCC_OFFSET_RST;
            s.dacOut   <= EDCC_HALF_MID[12:0];
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata           = s.prdata;
    assign pready           = s.pready;
    assign pslverr          = s.pslverr;
    assign ampGainSelect    = s.gainSel;
    assign attenuatorEnable = s.atten;
    assign highSpeedMode    = s.highSpeed;
    assign dacCode          = s.dacOut;
    assign dacUpdate        = s.dacUpdate;

endmodule

// File: edcc_pkg.sv
// Constants, register map and reset values for the excitation DAC control.
// What this block does
// - Gain select bit: clear gain 2, set 0.25
// - Update rate is clock divided by rate field
// - Attenuator bit: clear unity, set gain 0.2
// - Code register feeds converter, resets to midscale
// - Code 0x800 is zero volts, offset binary
// - Low power mode picks attenuated/direct offset trim
// - High speed mode uses its own trim pair
// - One gain trim scales swing in all modes
// - Trim registers writable only after unlock key
// - Gain trim unsigned, 0x800 means no change
// - Offset trim signed half-LSB, added to code
package edcc_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [15:0] EDCC_CONFIG_OFF   = 16'h2010;
    localparam logic [15:0] EDCC_CODE_OFF     = 16'h2048;
    localparam logic [15:0] EDCC_LOCK_OFF     = 16'h2230;
    localparam logic [15:0] EDCC_GAIN_OFF     = 16'h2260;
    localparam logic [15:0] EDCC_OFF_ATT_LP   = 16'h2264;
    localparam logic [15:0] EDCC_OFF_DIR_LP   = 16'h2268;
    localparam logic [15:0] EDCC_OFF_ATT_HS   = 16'h22B8;
    localparam logic [15:0] EDCC_OFF_DIR_HS   = 16'h22BC;
    localparam logic [15:0] EDCC_MODE_OFF     = 16'h2300;
    localparam logic [15:0] EDCC_STATUS_OFF   = 16'h2304;

    // ==========================================================
    // Field positions
    localparam int EDCC_GAIN_SEL_BIT  = 12;
    localparam int EDCC_SPARE_LSB     = 9;
    localparam int EDCC_RATE_LSB      = 1;
    localparam int EDCC_ATTEN_BIT     = 0;
    localparam int EDCC_UNLOCKED_BIT  = 16;

    // ==========================================================
    // Reset values and keys
    localparam logic [31:0] EDCC_CONFIG_RST   = 32'h0000001E;
    localparam logic [11:0] EDCC_CODE_RST     = 12'h800;
    localparam logic [31:0] EDCC_LOCK_RST     = 32'hDE87A5A0;
    localparam logic [31:0] EDCC_UNLOCK_KEY   = 32'hDE87A5AF;
    localparam logic [11:0] EDCC_GAIN_RST     = 12'h800;
    localparam logic [11:0] EDCC_OFFSET_RST   = 12'h000;

    // ==========================================================
    // Datapath constants
    localparam logic signed [12:0] EDCC_MIDSCALE      = 13'sh0800;
    localparam int                 EDCC_GAIN_SHIFT    = 14;
    localparam logic signed [15:0] EDCC_HALF_MID      = 16'sh1000;
    localparam logic signed [15:0] EDCC_HALF_MAX      = 16'sh1FFF;
    localparam logic [7:0]         EDCC_RATE_MIN      = 8'h01;

endpackage

// File: edcc_rate_divider.sv
// Update-rate divider producing a one-cycle tick every rate clocks, or every clock for rate 0.
`timescale 1ns/1ns
module edcc_rate_divider
    import edcc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Division ratio and tick
    input  wire logic [7:0] rate,
    output logic            tick
);
    import edcc_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } edcc_div_state_t;

    edcc_div_state_t s;
    edcc_div_state_t next_s;

    // ==========================================================
    // Divider
    always_comb begin
        next_s = s;
        if (rate <= EDCC_RATE_MIN || s.count >= rate - EDCC_RATE_MIN) begin
            next_s.count = 8'h00;
            next_s.tick  = 1'b1;
        end else begin
            next_s.count = s.count + 8'h01;
            next_s.tick  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule

// File: edcc_trim_path.sv
// Combinational gain and offset trim of the DAC code, in half-LSB units.
`timescale 1ns/1ns
module edcc_trim_path
    import edcc_pkg::*;
(
    // Raw code and trims
    input  wire logic [11:0] code,
    input  wire logic [11:0] gainTrim,
    input  wire logic [11:0] offsetTrim,
    // Trimmed converter code, twice the resolution of the raw code
    output logic      [12:0] trimmed
);
    import edcc_pkg::*;

    logic signed [12:0] centered;
    logic signed [12:0] gainDelta;
    logic signed [25:0] product;
    logic signed [13:0] scaled;
    logic signed [15:0] half;

    always_comb begin
        centered  = $signed({1'b0, code}) - EDCC_MIDSCALE;
        gainDelta = $signed({1'b0, gainTrim}) - EDCC_MIDSCALE;
        product   = centered * gainDelta;
        scaled    = {centered[12], centered}
                  + {{2{product[25]}}, product[25:EDCC_GAIN_SHIFT]};
        half      = {scaled[13], scaled, 1'b0}
                  + {{4{offsetTrim[11]}}, offsetTrim}
                  + EDCC_HALF_MID;
        if (half < 16'sh0000) begin
            trimmed = 13'h0000;
        end else if (half > EDCC_HALF_MAX) begin
            trimmed = EDCC_HALF_MAX[12:0];
        end else begin
            trimmed = half[12:0];
        end
    end

endmodule

// File: edcc_top_monitor.sv
// Port checker for the excitation DAC control.
`timescale 1ns/1ns
module edcc_top_monitor
    import edcc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Outputs
    input wire logic        ampGainSelect,
    input wire logic        attenuatorEnable,
    input wire logic        highSpeedMode,
    input wire logic [12:0] dacCode,
    input wire logic        dacUpdate
);
    // ====
    // Update spacing, skipped for intervals that saw a rate write.
    logic [8:0] gap;
    logic [7:0] rate;
    logic       chg;
    logic       seen;
    logic       cfgWr;
    assign cfgWr = psel && penable && pready && pwrite
                   && paddr == EDCC_CONFIG_OFF;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 9'h000;
            rate <= 8'h0F;
            chg <= 1'b0;
            seen <= 1'b0;
        end else begin
            gap <= dacUpdate ? 9'h001 : (gap == 9'h1FF ? gap : gap + 9'h001);
            chg <= cfgWr | (chg & !dacUpdate);
            seen <= seen | dacUpdate;
            if (cfgWr) begin
                rate <= {pstrb[1] ? pwdata[8] : rate[7],
                         pstrb[0] ? pwdata[7:1] : rate[6:0]};
            end
        end
    end
    // ====
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_ready_after_setup; psel && !penable |=> pready; endproperty
    property p_ready_one; pready |=> !pready; endproperty
    property p_err_in_ready; pslverr |-> pready; endproperty
    property p_unaligned; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
    endproperty
    property p_upd_pulse;
        dacUpdate && !chg && rate > 8'h01 |=> !dacUpdate;
    endproperty
    property p_code_on_update; !$stable(dacCode) |-> dacUpdate; endproperty
    property p_gain_sel;
        cfgWr && pstrb[1] |=> ampGainSelect == $past(pwdata[12]);
    endproperty
    property p_atten;
        cfgWr && pstrb[0] |=> attenuatorEnable == $past(pwdata[0]);
    endproperty
    property p_rate;
        dacUpdate && seen && !chg |->
            gap == ((rate == 8'h00) ? 9'h001 : {1'b0, rate});
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    a_ready_one: assert property (p_ready_one)
        else $error("ready longer than one cycle");
    a_err_in_ready: assert property (p_err_in_ready)
        else $error("error without ready");
    a_unaligned: assert property (p_unaligned)
        else $error("unaligned access not refused");
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("update pulse too long");
    a_code_on_update: assert property (p_code_on_update)
        else $error("code changed without update");
    a_gain_sel: assert property (p_gain_sel)
        else $error("gain select not following write");
    a_atten: assert property (p_atten)
        else $error("attenuator not following write");
    a_rate: assert property (p_rate)
        else $error("update spacing differs from rate");
    c_update: cover property (dacUpdate);
    c_error: cover property (pslverr);
    c_gain: cover property (cfgWr && pwdata[12]);
endmodule

bind edcc_top edcc_top_monitor u_edcc_top_monitor (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ampGainSelect(ampGainSelect), .attenuatorEnable(attenuatorEnable),
    .highSpeedMode(highSpeedMode), .dacCode(dacCode), .dacUpdate(dacUpdate));

// File: test_excitation_dac_control_cal.sv
// Register-level testbench of the excitation DAC control.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin \
    badCount++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module test_excitation_dac_control_cal;
    import edcc_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready, pslverr, ampGainSelect, attenuatorEnable;
    logic        highSpeedMode, dacUpdate;
    logic [12:0] dacCode;
    logic [11:0] cd;
    logic [1:0]  sel;
    int          badCount = 0;
    int          nChecks = 0;
    int          gap, m;
    logic [15:0] ra [9] = '{EDCC_CONFIG_OFF, EDCC_CODE_OFF, EDCC_LOCK_OFF,
        EDCC_GAIN_OFF, EDCC_OFF_ATT_LP, EDCC_OFF_DIR_LP, EDCC_OFF_ATT_HS,
        EDCC_OFF_DIR_HS, EDCC_STATUS_OFF};
    logic [31:0] rv [9] = '{32'h1E, 32'h800, 32'hDE87A5A0, 32'h800, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h1000};
    // Offset trims indexed by {high speed, attenuator}.
    logic [15:0] oa [4] = '{EDCC_OFF_DIR_LP, EDCC_OFF_ATT_LP,
        EDCC_OFF_DIR_HS, EDCC_OFF_ATT_HS};
    logic [11:0] ov [4] = '{12'hFFF, 12'h001, 12'h7FF, 12'h800};

    always #20 clk = ~clk;

    edcc_top u_edcc_top (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ampGainSelect(ampGainSelect), .attenuatorEnable(attenuatorEnable),
        .highSpeedMode(highSpeedMode), .dacCode(dacCode),
        .dacUpdate(dacUpdate));

    // Expected converter code in half-LSB units, clamped to 13 bits.
    function automatic logic [12:0] expc(logic [11:0] c, g, o);
        int s, v;
        s = int'(c) - 2048;
        s = s + ((s * (int'(g) - 2048)) >>> 14);
        v = 2 * s + int'($signed(o)) + 4096;
        return (v < 0) ? 13'h0 : (v > 8191) ? 13'h1FFF : v[12:0];
    endfunction

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            badCount++;
            closeOut();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK("prdata", x, q)
        `CHK("pslverr", xe, e)
    endtask

    // Counts clock edges until the next converter update.
    task automatic upd(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dacUpdate !== 1'b1 && n < 600);
        if (dacUpdate !== 1'b1) begin
            badCount++;
            closeOut();
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (m = 0; m < 9; m++) rd(ra[m], rv[m], 1'b0);
        `CHK("dacCode", 13'h1000, dacCode)
        rd(16'h2400, 32'h0, 1'b1);
        rd(16'h2012, 32'h0, 1'b1);
        wr(EDCC_GAIN_OFF, 32'h123);
        rd(EDCC_GAIN_OFF, 32'h800, 1'b0);
        wr(EDCC_LOCK_OFF, EDCC_UNLOCK_KEY);
        rd(EDCC_STATUS_OFF, 32'h11000, 1'b0);
        wr(EDCC_GAIN_OFF, 32'hFFFFF123);
        rd(EDCC_GAIN_OFF, 32'h123, 1'b0);
        wr(EDCC_GAIN_OFF, 32'h800);
        for (m = 0; m < 4; m++) wr(oa[m], {20'h0, ov[m]});
        for (m = 0; m < 8; m++) begin
            cd = (m == 7) ? 12'hE00 : 12'h200 + 12'(m) * 12'h100;
            sel = {m[2], m[0]};
            wr(EDCC_MODE_OFF, {31'h0, m[2]});
            wr(EDCC_CONFIG_OFF, {19'h7FFFF, m[1], 3'h5, 8'h03, m[0]});
            rd(EDCC_CONFIG_OFF, {19'h0, m[1], 3'h5, 8'h03, m[0]}, 1'b0);
            wr(EDCC_CODE_OFF, {20'hFFFFF, cd});
            rd(EDCC_CODE_OFF, {20'h0, cd}, 1'b0);
            `CHK("ampGainSelect", m[1], ampGainSelect)
            `CHK("attenuatorEnable", m[0], attenuatorEnable)
            `CHK("highSpeedMode", m[2], highSpeedMode)
            upd(gap);
            upd(gap);
            `CHK("gap", 3, gap)
            `CHK("dacCode", expc(cd, 12'h800, ov[sel]), dacCode)
        end
        for (m = 0; m < 2; m++) begin
            cd = m ? 12'hFFF : 12'h000;
            wr(EDCC_GAIN_OFF, {20'h0, cd});
            upd(gap);
            upd(gap);
            `CHK("dacCode", expc(12'hE00, cd, ov[3]), dacCode)
        end
        pstrb <= 4'h1;
        wr(EDCC_CONFIG_OFF, 32'hFFFFFF04);
        pstrb <= 4'hF;
        rd(EDCC_CONFIG_OFF, 32'h1A04, 1'b0);
        `CHK("attenuatorEnable", 1'b0, attenuatorEnable)
        upd(gap);
        upd(gap);
        `CHK("gap", 2, gap)
        wr(EDCC_LOCK_OFF, 32'h0);
        wr(EDCC_GAIN_OFF, 32'h800);
        rd(EDCC_GAIN_OFF, 32'hFFF, 1'b0);
        closeOut();
    end
endmodule
